// ---- rtl/ufb_core.sv ----
// usart frame-format and baud configuration registers
// assumes shifters sit outside and talk over the rx/tx check ports
`timescale 1ns/100ps
module ufb_core
    import ufb_pkg::*;
#(
    parameter int CHAR_W = 9
) (
    // clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_b,
    // register port
    input  wire logic [3:0]        i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [7:0]        o_rdata,
    // transmit side: data of the frame being built
    input  wire logic [CHAR_W-1:0] i_tx_data,
    output logic                   o_tx_parity_bit,
    output logic                   o_tx_parity_en,
    output logic      [1:0]        o_tx_stop_bits,
    // receive side: finished character with its parity bit
    input  wire logic              i_rx_done,
    input  wire logic [CHAR_W-1:0] i_rx_data,
    input  wire logic              i_rx_parity_bit,
    input  wire logic              i_rx_read,
    // shared format and baud
    output logic      [3:0]        o_data_bits,
    output logic                   o_master_serial_periph_mode,
    output logic                   o_lsb_first,
    output logic                   o_sample_trailing,
    output logic      [11:0]       o_baud_divider,
    output logic      [3:0]        o_baud_scale,
    output logic                   o_scale_negative,
    output logic      [2:0]        o_scale_magnitude,
    output logic                   o_prescaler_reload,
    // interrupt
    output logic                   o_irq
);
    initial begin
        if (CHAR_W != 9) $error("ufb_core: CHAR_W must be 9");
    end

    logic [7:0] frame_reg,  frame_next;
    logic [7:0] baudl_reg,  baudl_next;
    logic [7:0] baudh_reg,  baudh_next;
    logic       parity_error_flag_reg,   parity_error_flag_next;
    logic [1:0] irq_st_reg, irq_st_next;
    logic [1:0] irq_en_reg, irq_en_next;
    logic       reload_reg, reload_next;
    logic [7:0] rdata_reg,  rdata_next;
    ufb_fmt_s   fmt_reg,    fmt_next;
    logic       irq_reg,    irq_next;
    logic       par_tx_reg, par_tx_next;
    logic       neg_reg,    neg_next;
    logic [2:0] mag_reg,    mag_next;

    ufb_frame_s frame_f;
    ufb_fmt_s   fmt_c;
    logic       wr_data_area;
    logic       rx_par_calc;
    logic       tx_par_calc;
    logic       sc_neg;
    logic [2:0] sc_mag;
    logic       sc_rsvd;
    logic [1:0] irq_set;

    assign frame_f = ufb_frame_s'(frame_reg);

    // format decode from the frame register
    always_comb begin
        fmt_c = '0;
        fmt_c.master_serial_periph_mode =
            (frame_f.comm_mode_sel == UFB_MODE_MASTER_SERIAL_PERIPH_MODE);
        fmt_c.parity_en = ~fmt_c.master_serial_periph_mode &
            ((frame_f.parity_type_sel == UFB_PAR_EVEN) |
             (frame_f.parity_type_sel == UFB_PAR_ODD));
        fmt_c.parity_odd = (frame_f.parity_type_sel == UFB_PAR_ODD);
        // stop count only matters to the transmitter
        fmt_c.stop_bits = frame_f.stop_bit_count_sel ? 2'h2 : 2'h1;
        if (frame_f.char_width_sel == UFB_CHW_9) begin
            fmt_c.data_bits = 4'h9;
        end else begin
            // reserved codes fall back to 8 bits
            fmt_c.data_bits = frame_f.char_width_sel[2] ? 4'h8 :
                4'(frame_f.char_width_sel[1:0]) + 4'h5;
        end
        fmt_c.bit_order_sel   = frame_reg[UFB_POS_ORDER];
        fmt_c.sample_edge_sel = frame_reg[UFB_POS_EDGE];
    end

    ufb_parity_gen #(.W(CHAR_W)) u_tx_par (
        .i_data   (i_tx_data),
        .i_nbits  (fmt_reg.data_bits),
        .i_odd    (fmt_reg.parity_odd),
        .o_parity (tx_par_calc)
    );

    ufb_parity_gen #(.W(CHAR_W)) u_rx_par (
        .i_data   (i_rx_data),
        .i_nbits  (fmt_reg.data_bits),
        .i_odd    (fmt_reg.parity_odd),
        .o_parity (rx_par_calc)
    );

    ufb_scale_decode u_scale (
        .i_code      (baudh_reg[7:UFB_POS_SCALE]),
        .o_negative  (sc_neg),
        .o_magnitude (sc_mag),
        .o_reserved  (sc_rsvd)
    );

    assign wr_data_area = i_wr & (i_addr[3] == 1'b0);

    // register writes, parity check and interrupt state
    always_comb begin
        frame_next  = frame_reg;
        baudl_next  = baudl_reg;
        baudh_next  = baudh_reg;
        parity_error_flag_next   = parity_error_flag_reg;
        irq_en_next = irq_en_reg;
        reload_next = 1'b0;
        irq_set     = 2'h0;
        if (wr_data_area) begin
            case (i_addr[2:0])
                UFB_OFS_FRAME: frame_next = i_wdata;
                UFB_OFS_BAUDL: begin
                    baudl_next  = i_wdata;
                    reload_next = 1'b1;
                end
                UFB_OFS_BAUDH: baudh_next = i_wdata;
                default: ;
            endcase
        end
        if (i_wr && i_addr == UFB_OFS_IRQ_EN) begin
            irq_en_next = i_wdata[1:0];
        end
        // flag follows the buffered character until software reads it
        if (i_rx_read) begin
            parity_error_flag_next = 1'b0;
        end
        if (i_rx_done) begin
            parity_error_flag_next = fmt_reg.parity_en &
                (rx_par_calc != i_rx_parity_bit);
        end
        if (!fmt_reg.parity_en) begin
            parity_error_flag_next = 1'b0;
        end
        irq_set[UFB_IRQ_PARITY_ERROR_FLAG]   = i_rx_done & fmt_reg.parity_en &
                                  (rx_par_calc != i_rx_parity_bit);
        irq_set[UFB_IRQ_RELOAD] = reload_next;
        irq_st_next = irq_st_reg;
        if (i_wr && i_addr == UFB_OFS_IRQ_CLR) begin
            irq_st_next = irq_st_reg & ~i_wdata[1:0];
        end
        // a new event beats a clear in the same cycle
        irq_st_next = irq_st_next | irq_set;
        irq_next    = |(irq_st_next & irq_en_next);
        fmt_next    = fmt_c;
        par_tx_next = tx_par_calc;
        neg_next    = sc_neg;
        mag_next    = sc_rsvd ? 3'h0 : sc_mag;
    end

    // read mux; data read answers one cycle after the strobe
    always_comb begin
        rdata_next = 8'h00;
        if (i_rd) begin
            case (i_addr)
                {1'b0, UFB_OFS_STATUS}: rdata_next =
                    8'(parity_error_flag_reg) << UFB_POS_PARITY_ERROR_FLAG;
                {1'b0, UFB_OFS_FRAME}: rdata_next = frame_reg;
                {1'b0, UFB_OFS_BAUDL}: rdata_next = baudl_reg;
                {1'b0, UFB_OFS_BAUDH}: rdata_next = baudh_reg;
                UFB_OFS_IRQ_ST:        rdata_next = {6'h00, irq_st_reg};
                UFB_OFS_IRQ_EN:        rdata_next = {6'h00, irq_en_reg};
                default:               rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            frame_reg  <= UFB_RST_FRAME;
            baudl_reg  <= UFB_RST_BAUD;
            baudh_reg  <= UFB_RST_BAUD;
            parity_error_flag_reg   <= 1'b0;
            irq_st_reg <= 2'h0;
            irq_en_reg <= 2'h0;
            reload_reg <= 1'b0;
            rdata_reg  <= 8'h00;
            fmt_reg    <= '{1'b0, 1'b0, 1'b0, 2'h1, 4'h8, 1'b0, 1'b0};
            irq_reg    <= 1'b0;
            par_tx_reg <= 1'b0;
            neg_reg    <= 1'b0;
            mag_reg    <= 3'h0;
        end else begin
            frame_reg  <= frame_next;
            baudl_reg  <= baudl_next;
            baudh_reg  <= baudh_next;
            parity_error_flag_reg   <= parity_error_flag_next;
            irq_st_reg <= irq_st_next;
            irq_en_reg <= irq_en_next;
            reload_reg <= reload_next;
            rdata_reg  <= rdata_next;
            fmt_reg    <= fmt_next;
            irq_reg    <= irq_next;
            par_tx_reg <= par_tx_next;
            neg_reg    <= neg_next;
            mag_reg    <= mag_next;
        end
    end

    // every output straight from a flip-flop
    assign o_rdata            = rdata_reg;
    assign o_tx_parity_bit    = par_tx_reg;
    assign o_tx_parity_en     = fmt_reg.parity_en;
    assign o_tx_stop_bits     = fmt_reg.stop_bits;
    assign o_data_bits        = fmt_reg.data_bits;
    assign o_master_serial_periph_mode             = fmt_reg.master_serial_periph_mode;
    assign o_lsb_first        = fmt_reg.bit_order_sel;
    assign o_sample_trailing  = fmt_reg.sample_edge_sel;
    // divider and scale are the stored registers themselves
    assign o_baud_divider     = {baudh_reg[3:0], baudl_reg};
    assign o_baud_scale       = baudh_reg[7:UFB_POS_SCALE];
    assign o_scale_negative   = neg_reg;
    assign o_scale_magnitude  = mag_reg;
    assign o_prescaler_reload = reload_reg;
    assign o_irq              = irq_reg;
endmodule

// ---- rtl/ufb_pkg.sv ----
// package for the usart frame-format / baud configuration block
// assumes one clock domain and an 8-bit register port
// What this block does
// - parity mode 00 off, 10 even, 11 odd, 01 reserved
// - transmitter computes parity over data bits and inserts it
// - receiver checks parity against selected type, sets error on mismatch
// - parity mode ignored in master spi mode
// - stop select 0 gives one stop bit, 1 gives two; unused in spi
// - receiver ignores stop-bit count
// - width codes 000..011 give 5..8 bits, 111 gives 9; shared setting
// - spi bit order one sends lsb first, zero msb first, both directions
// - spi sample-edge select picks leading or trailing clock edge
// - divider is 12 bits: low register 7:0, high register 3:0 gives 11:8
// - writing the low divider byte pulses the prescaler reload one clock after the write
// - scale exponent in high register 7:4, two's complement -7..+7
// - mode field 11 selects master spi
// - parity error flag reads zero while parity checking is off
package ufb_pkg;
    localparam logic [2:0] UFB_OFS_DATA   = 3'h0;
    localparam logic [2:0] UFB_OFS_STATUS = 3'h1;
    localparam logic [2:0] UFB_OFS_RSVD   = 3'h2;
    localparam logic [2:0] UFB_OFS_INTLVL = 3'h3;
    localparam logic [2:0] UFB_OFS_DIREN  = 3'h4;
    localparam logic [2:0] UFB_OFS_FRAME  = 3'h5;
    localparam logic [2:0] UFB_OFS_BAUDL  = 3'h6;
    localparam logic [2:0] UFB_OFS_BAUDH  = 3'h7;
    // own registers: interrupt status, clear, enable
    localparam logic [3:0] UFB_OFS_IRQ_ST  = 4'h8;
    localparam logic [3:0] UFB_OFS_IRQ_CLR = 4'h9;
    localparam logic [3:0] UFB_OFS_IRQ_EN  = 4'ha;

    localparam logic [7:0] UFB_RST_FRAME = 8'h03;
    localparam logic [7:0] UFB_RST_BAUD  = 8'h00;

    localparam int UFB_POS_MODE   = 6;
    localparam int UFB_POS_PAR    = 4;
    localparam int UFB_POS_STOP   = 3;
    localparam int UFB_POS_ORDER  = 2;
    localparam int UFB_POS_EDGE   = 1;
    localparam int UFB_POS_SCALE  = 4;
    localparam int UFB_POS_PARITY_ERROR_FLAG   = 2;

    localparam logic [1:0] UFB_MODE_MASTER_SERIAL_PERIPH_MODE  = 2'h3;
    localparam logic [1:0] UFB_PAR_OFF    = 2'h0;
    localparam logic [1:0] UFB_PAR_EVEN   = 2'h2;
    localparam logic [1:0] UFB_PAR_ODD    = 2'h3;
    localparam logic [2:0] UFB_CHW_9      = 3'h7;

    // irq status bit positions
    localparam int UFB_IRQ_PARITY_ERROR_FLAG   = 0;
    localparam int UFB_IRQ_RELOAD = 1;

    typedef struct packed {
        logic [1:0] comm_mode_sel;
        logic [1:0] parity_type_sel;
        logic       stop_bit_count_sel;
        logic [2:0] char_width_sel;
    } ufb_frame_s;

    typedef struct packed {
        logic        master_serial_periph_mode;
        logic        parity_en;
        logic        parity_odd;
        logic [1:0]  stop_bits;
        logic [3:0]  data_bits;
        logic        bit_order_sel;
        logic        sample_edge_sel;
    } ufb_fmt_s;

    typedef struct packed {
        logic [11:0] baud_divider_value;
        logic [3:0]  baud_scale_exponent;
    } ufb_baud_s;
endpackage

// ---- rtl/ufb_parity_gen.sv ----
// parity of the low n data bits of a 9-bit character
// assumes width code already decoded to a bit count 5..9
`timescale 1ns/100ps
module ufb_parity_gen
    import ufb_pkg::*;
#(
    parameter int W = 9
) (
    // data in
    input  wire logic [W-1:0] i_data,
    input  wire logic [3:0]   i_nbits,
    input  wire logic         i_odd,
    // parity out
    output logic              o_parity
);
    initial begin
        if (W < 5) $error("ufb_parity_gen: W below 5");
    end
    logic [W-1:0] masked;
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_mask
            assign masked[g] = i_data[g] & (4'(g) < i_nbits);
        end
    endgenerate
    assign o_parity = (^masked) ^ i_odd;
endmodule

// ---- rtl/ufb_scale_decode.sv ----
// decodes the signed scale exponent nibble
// reserved code -8 is flagged rather than used
`timescale 1ns/100ps
module ufb_scale_decode
    import ufb_pkg::*;
(
    // raw nibble
    input  wire logic [3:0] i_code,
    // decoded
    output logic            o_negative,
    output logic [2:0]      o_magnitude,
    output logic            o_reserved
);
    logic [3:0] neg;
    assign neg         = 4'(~i_code + 4'h1);
    assign o_reserved  = (i_code == 4'h8);
    assign o_negative  = i_code[3] & ~o_reserved;
    assign o_magnitude = i_code[3] ? neg[2:0] : i_code[2:0];
endmodule

// ---- verification/ufb_core_monitor.sv ----
// port assertions for the frame-format and baud configuration block
// bound into every ufb_core; one clock domain, reset active low
`timescale 1ns/100ps
module ufb_core_monitor
    import ufb_pkg::*;
(
    // clock and register port
    input wire logic        i_ref_clk,
    input wire logic        i_rst_b,
    input wire logic [3:0]  i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    // watched outputs
    input wire logic [7:0]  o_rdata,
    input wire logic [1:0]  o_tx_stop_bits,
    input wire logic        o_tx_parity_en,
    input wire logic [3:0]  o_data_bits,
    input wire logic        o_master_serial_periph_mode,
    input wire logic        o_lsb_first,
    input wire logic        o_sample_trailing,
    input wire logic [11:0] o_baud_divider,
    input wire logic [3:0]  o_baud_scale,
    input wire logic        o_prescaler_reload
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // decoded format lags the write by two cycles
    sequence frame_wr;
        i_wr && i_addr == 4'h5 ##1 !(i_wr && i_addr == 4'h5);
    endsequence
    reload_pulse_a: assert property (i_wr && i_addr == 4'h6 |=>
        o_prescaler_reload && o_baud_divider[7:0] == $past(i_wdata))
        else $error("reload or low divider wrong");
    reload_cause_a: assert property (o_prescaler_reload
        |-> $past(i_wr && i_addr == 4'h6)) else $error("stray reload");
    baud_high_a: assert property (i_wr && i_addr == 4'h7 |=>
        {o_baud_scale, o_baud_divider[11:8]} == $past(i_wdata))
        else $error("high baud fields wrong");
    stop_count_a: assert property (frame_wr |=>
        $past(i_wdata[7:6], 2) == UFB_MODE_MASTER_SERIAL_PERIPH_MODE ||
        o_tx_stop_bits == ($past(i_wdata[3], 2) ? 2'h2 : 2'h1))
        else $error("stop count wrong");
    char_width_a: assert property (frame_wr |=>
        $past(i_wdata[7:6], 2) == UFB_MODE_MASTER_SERIAL_PERIPH_MODE || o_data_bits ==
        ($past(i_wdata[2:0], 2) == 3'h7 ? 4'h9 : 4'h5 + $past(i_wdata[2:0], 2)))
        else $error("data width wrong");
    parity_on_a: assert property (frame_wr |=> o_tx_parity_en ==
        ($past(i_wdata[5], 2) && $past(i_wdata[7:6], 2) != UFB_MODE_MASTER_SERIAL_PERIPH_MODE))
        else $error("parity enable wrong");
    spi_setup_a: assert property (frame_wr |=>
        o_master_serial_periph_mode == ($past(i_wdata[7:6], 2) == UFB_MODE_MASTER_SERIAL_PERIPH_MODE) && (!o_master_serial_periph_mode ||
        {o_lsb_first, o_sample_trailing} == $past(i_wdata[2:1], 2)))
        else $error("spi order or edge wrong");
    rdata_quiet_a: assert property (!$past(i_rd) || $past(i_addr) > 4'ha
        |-> o_rdata == 8'h0) else $error("read data outside read slot");
    cover property (frame_wr ##1 o_master_serial_periph_mode);
    cover property (o_prescaler_reload);
    cover property (i_rd && i_addr == 4'h1 ##1 o_rdata[2]);
endmodule

bind ufb_core ufb_core_monitor ufb_core_monitor_i (
    .i_ref_clk          (i_ref_clk),
    .i_rst_b            (i_rst_b),
    .i_addr             (i_addr),
    .i_wdata            (i_wdata),
    .i_wr               (i_wr),
    .i_rd               (i_rd),
    .o_rdata            (o_rdata),
    .o_tx_stop_bits     (o_tx_stop_bits),
    .o_tx_parity_en     (o_tx_parity_en),
    .o_data_bits        (o_data_bits),
    .o_master_serial_periph_mode             (o_master_serial_periph_mode),
    .o_lsb_first        (o_lsb_first),
    .o_sample_trailing  (o_sample_trailing),
    .o_baud_divider     (o_baud_divider),
    .o_baud_scale       (o_baud_scale),
    .o_prescaler_reload (o_prescaler_reload)
);

// ---- verification/ufb_partner.sv ----
// remote transceiver model: hands finished characters to the receiver
// assumes the bench tells it the agreed width and parity type
`timescale 1ns/100ps
module ufb_partner
    import ufb_pkg::*;
(
    // clock and agreed format
    input  wire logic       i_ref_clk,
    input  wire logic [3:0] i_nbits,
    input  wire logic       i_odd,
    // character towards the block
    output logic            o_done,
    output logic [8:0]      o_data,
    output logic            o_parity_bit
);
    initial o_done = 1'b0;
    initial o_data = 9'h0;
    initial o_parity_bit = 1'b0;
    // bad flips the parity bit, as a noisy line would
    task automatic send(input logic [8:0] d, input logic bad);
        logic p;
        p = i_odd;
        for (int k = 0; k < 9; k++) if (k < i_nbits) p ^= d[k];
        @(posedge i_ref_clk);
        {o_done, o_data, o_parity_bit} <= {1'b1, d, p ^ bad};
        @(posedge i_ref_clk);
        // stale lines show the inverse so a late sample cannot pass
        {o_done, o_data, o_parity_bit} <= {1'b0, ~d, ~(p ^ bad)};
    endtask
endmodule

// ---- verification/ufb_core_tb_top.sv ----
// self-checking bench for ufb_core with the remote transceiver model
// assumes the checker binds itself from its own file
`timescale 1ns/100ps
module ufb_core_tb_top
    import ufb_pkg::*;
;
    logic        i_ref_clk, i_rst_b, i_wr, i_rd, i_rx_read, odd;
    logic        rd_d = 1'b0;
    logic        i_rx_done, i_rx_parity_bit, o_tx_parity_bit, o_irq;
    logic        o_tx_parity_en, o_master_serial_periph_mode, o_lsb_first, o_sample_trailing;
    logic        o_scale_negative, o_prescaler_reload;
    logic [3:0]  i_addr, o_data_bits, o_baud_scale, nbits;
    logic [7:0]  i_wdata, o_rdata, rd_q[$];
    logic [8:0]  i_tx_data, i_rx_data;
    logic [1:0]  o_tx_stop_bits, pt[3] = '{2'h0, 2'h2, 2'h3};
    logic [2:0]  o_scale_magnitude, cw[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic [11:0] o_baud_divider;
    int          fail_count, cmp_count;
    ufb_core ufb_core_i (
        .i_ref_clk          (i_ref_clk),
        .i_rst_b            (i_rst_b),
        .i_addr             (i_addr),
        .i_wdata            (i_wdata),
        .i_wr               (i_wr),
        .i_rd               (i_rd),
        .o_rdata            (o_rdata),
        .i_tx_data          (i_tx_data),
        .o_tx_parity_bit    (o_tx_parity_bit),
        .o_tx_parity_en     (o_tx_parity_en),
        .o_tx_stop_bits     (o_tx_stop_bits),
        .i_rx_done          (i_rx_done),
        .i_rx_data          (i_rx_data),
        .i_rx_parity_bit    (i_rx_parity_bit),
        .i_rx_read          (i_rx_read),
        .o_data_bits        (o_data_bits),
        .o_master_serial_periph_mode             (o_master_serial_periph_mode),
        .o_lsb_first        (o_lsb_first),
        .o_sample_trailing  (o_sample_trailing),
        .o_baud_divider     (o_baud_divider),
        .o_baud_scale       (o_baud_scale),
        .o_scale_negative   (o_scale_negative),
        .o_scale_magnitude  (o_scale_magnitude),
        .o_prescaler_reload (o_prescaler_reload),
        .o_irq              (o_irq)
    );
    ufb_partner ufb_partner_i (.i_ref_clk(i_ref_clk), .i_nbits(nbits),
        .i_odd(odd), .o_done(i_rx_done), .o_data(i_rx_data),
        .o_parity_bit(i_rx_parity_bit));
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_ref_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_ref_clk) i_wr <= 1'b0;
    endtask
    // expected read data waits in the queue for the watcher below
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_ref_clk) {i_rd, i_addr} <= {1'b1, a};
        rd_q.push_back(e);
        @(posedge i_ref_clk) i_rd <= 1'b0;
    endtask
    task automatic settle;
        repeat (3) @(posedge i_ref_clk);
        #1;
    endtask
    always @(posedge i_ref_clk) begin
        if (rd_d) cmp(o_rdata, rd_q.pop_front());
        rd_d <= i_rd;
    end
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #300000;
        fail_count++;
        give_verdict;
    end
    initial begin
        logic [7:0] f, h, l;
        logic [8:0] d;
        logic       p;
        {i_rst_b, i_wr, i_rd, i_rx_read, odd} = 5'h0;
        {i_addr, i_wdata, i_tx_data, nbits} = {4'h0, 8'h0, 9'h0, 4'h8};
        void'($urandom(32'h4878));
        repeat (2) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        #1;
        cmp({o_tx_stop_bits, o_data_bits}, {2'h1, 4'h8});
        cmp({o_irq, o_prescaler_reload, o_master_serial_periph_mode}, 3'h0);
        wr(4'hb, 8'hff);
        rd(4'h5, UFB_RST_FRAME);
        rd(4'h7, 8'h0);
        rd(4'hf, 8'h0);
        $display("test reset done");
        foreach (pt[i]) for (int s = 0; s < 2; s++) foreach (cw[j]) begin
            f = {2'h0, pt[i], s[0], cw[j]};
            wr(4'h5, f);
            settle;
            nbits = (cw[j] == 3'h7) ? 4'h9 : 4'h5 + {1'b0, cw[j]};
            odd = pt[i][0];
            cmp(o_tx_stop_bits, s ? 2'h2 : 2'h1);
            cmp({o_data_bits, o_tx_parity_en},
                {nbits, pt[i][1]});
            d = 9'($urandom);
            @(posedge i_ref_clk) i_tx_data <= d;
            @(posedge i_ref_clk);
            #1;
            p = odd;
            for (int k = 0; k < 9; k++) if (k < nbits) p ^= d[k];
            if (pt[i][1]) cmp(o_tx_parity_bit, p);
            for (int b = 0; b < 2; b++) begin
                ufb_partner_i.send(9'($urandom), b[0]);
                rd(4'h1, {5'h0, b[0] & pt[i][1], 2'h0});
            end
            rd(4'h5, f);
        end
        // last pass ended on a bad odd-parity character: flag stands
        rd(4'h1, 8'h04);
        @(posedge i_ref_clk) i_rx_read <= 1'b1;
        @(posedge i_ref_clk) i_rx_read <= 1'b0;
        rd(4'h1, 8'h00);
        $display("test frame done");
        for (int m = 0; m < 4; m++) begin
            wr(4'h5, {2'h3, 2'h2, 1'b0, m[1:0], 1'b0});
            settle;
            cmp({o_master_serial_periph_mode, o_lsb_first, o_sample_trailing},
                {1'b1, m[1:0]});
            cmp(o_tx_parity_en, 1'b0);
            ufb_partner_i.send(9'($urandom), 1'b1);
            rd(4'h1, 8'h0);
        end
        $display("test spi done");
        for (int c = 0; c < 16; c++) if (c != 8) begin
            h = {c[3:0], 4'($urandom)};
            l = 8'($urandom);
            wr(4'h7, h);
            wr(4'h6, l);
            #1;
            cmp(o_prescaler_reload, 1'b1);
            settle;
            cmp(o_prescaler_reload, 1'b0);
            cmp(o_baud_divider, {h[3:0], l});
            cmp({o_baud_scale, o_scale_negative, o_scale_magnitude},
                {h[7:4], h[7], h[7] ? 3'(4'h0 - h[7:4]) : h[6:4]});
            rd(4'h7, h);
        end
        $display("test baud done");
        // reset again in mid-run: divider, low baud and frame registers must fall back
        @(posedge i_ref_clk) i_rst_b <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        #1;
        cmp(o_baud_divider, 12'h000);
        rd(4'h6, 8'h00);
        rd(4'h5, UFB_RST_FRAME);
        $display("test mid-run reset done");
        wr(4'h9, 8'h03);
        wr(4'ha, 8'h00);
        wr(4'h6, 8'h5a);
        settle;
        cmp(o_irq, 1'b0);
        rd(4'h8, 8'h02);
        wr(4'ha, 8'h02);
        settle;
        cmp(o_irq, 1'b1);
        wr(4'h9, 8'h02);
        settle;
        cmp(o_irq, 1'b0);
        rd(4'h8, 8'h00);
        repeat (3) @(posedge i_ref_clk);
        $display("test interrupt done");
        give_verdict;
    end
endmodule
